//--- common/ppp_pkg.sv
/*
 * Constants, encodings and types shared by the parallel programming port.
 * Assumes a 250 MHz core clock; all pin timing is converted from ns here.
 */
package ppp_pkg;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int ENTRY_QUIET_NS = 100;
    localparam int ENTRY_QUIET_CYC =
        (ENTRY_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] ENTRY_TOGGLES = 3'h6;

    // ************************************************************
    // Pin encodings
    // ************************************************************
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD = 2'h2;
    localparam logic [1:0] ACT_IDLE = 2'h3;
    localparam logic [1:0] BSEL_LO = 2'h0;
    localparam logic [1:0] BSEL_HI = 2'h1;
    localparam logic [1:0] BSEL_EXT = 2'h2;
    localparam logic [1:0] BSEL_FHI = 2'h3;

    // ************************************************************
    // Command bytes
    // ************************************************************
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
    localparam logic [7:0] CMD_WR_FUSE = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK = 8'h20;
    localparam logic [7:0] CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] CMD_WR_EE = 8'h11;
    localparam logic [7:0] CMD_RD_SIG = 8'h08;
    localparam logic [7:0] CMD_RD_FUSE = 8'h04;
    localparam logic [7:0] CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] CMD_RD_EE = 8'h03;
    localparam logic [7:0] CMD_NOP = 8'h00;

    // ************************************************************
    // Memory layout and reset values
    // ************************************************************
    localparam int PAGE_IDX_W = 6;
    localparam int EE_IDX_W = 2;
    localparam int ADDR_W = 24;
    localparam int KEEP_EE_BIT = 3;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] FUSE_LO_RST = 8'hFF;
    localparam logic [7:0] FUSE_HI_RST = 8'hFF;
    localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
    localparam logic [7:0] LOCK_RST = 8'hFF;
    localparam logic [1:0] SIG_LAST = 2'h2;

    // Operations requested from the nonvolatile array controller.
    typedef enum logic [2:0] {
        PPP_OP_NONE,
        PPP_OP_WR_FLASH,
        PPP_OP_WR_EE,
        PPP_OP_ER_FLASH,
        PPP_OP_ER_EE,
        PPP_OP_RD_FLASH,
        PPP_OP_RD_EE
    } ppp_arr_op_t;
endpackage

//--- design/ppp_sync.sv
/*
 * Two-flop synchroniser for a group of pins, plus one delayed copy so
 * the user can detect edges on synchronised data only.
 * Assumes each pin is held long enough to be seen by the core clock.
 */
`timescale 1ns/10ps
module ppp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Pins and synchronised copies
    input wire logic [W-1:0] pin,
    output logic [W-1:0] q,
    output logic [W-1:0] q_d
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= '0;
            q <= '0;
            q_d <= '0;
        end else begin
            meta_reg <= pin;
            q <= meta_reg;
            q_d <= q;
        end
    end
endmodule // ppp_sync

//--- design/ppp_mem.sv
/*
 * Small single-write, single-read page buffer with registered read data.
 * Assumes the user never reads and writes the same entry in one cycle.
 */
`timescale 1ns/10ps
module ppp_mem #(
    parameter int W = 16,
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    // Read port
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem [DEPTH];

    if (DEPTH > (1 << AW)) begin : g_chk
        $error("ppp_mem: DEPTH does not fit the address width");
    end

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule // ppp_mem

//--- design/ppp_top.sv
/*
 * Parallel programming port: pin sampling, mode entry, command decode,
 * page buffering, chip erase and the fuse, lock and signature readout.
 * Assumes an array controller on the same clock that answers each
 * request with a one-cycle ack; the high-voltage level is a logic input.
 */
// Operation
// - Strobe clock rise: action 00 address, 01 data, 10 command, 11 nothing.
// - Write or output-enable pulse runs the most recently loaded command.
// - Nine command bytes decode to erase, write and read operations.
// - Ready/busy low during erase or programming, high when ready; fuse and lock writes leave it high.
// - Data bus is input; driven only while output enable is low.
// - Byte-select pair chooses address, data, fuse or readout byte per use.
// - Entry fails if pattern pins change within 100 ns of high voltage.
// - Command and address bytes persist across successive operations.
// - Chip erase clears Flash, EEPROM and locks; fuses stay unchanged.
// - Lock bits reset only after Flash erase has completed.
// - Programmed keep-EEPROM fuse preserves EEPROM during chip erase.
// - Erase: load command, write pulse, busy until done.
// - Flash programmed per 64-word page, word index low six bits.
// - EEPROM paged in four bytes, indexed by low two address bits.
// - Page-latch pulse copies data bytes into buffer at word index.
// - Write pulse with select 00 programs the whole buffered page.
`timescale 1ns/10ps
module ppp_top
    import ppp_pkg::*;
#(
    parameter int PAGE_WORDS = 64,
    parameter int EE_PAGE_BYTES = 4,
    parameter logic [7:0] SIG_BYTE0 = 8'h5A,  // Arbitrary value.
    parameter logic [7:0] SIG_BYTE1 = 8'h3C,  // Arbitrary value.
    parameter logic [7:0] SIG_BYTE2 = 8'hC3,  // Arbitrary value.
    parameter logic [7:0] CAL_BYTE = 8'h80    // Arbitrary value.
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Programming pins
    input wire logic reset_pin_n,
    input wire logic hv_level,
    input wire logic strobe_clock_pin,
    input wire logic strobe_action_0,
    input wire logic strobe_action_1,
    input wire logic byte_select_lo,
    input wire logic byte_select_hi,
    input wire logic page_latch_strobe,
    input wire logic wr_n,
    input wire logic oe_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic ready_busy_n,
    // Mode status
    output logic prog_mode,
    // Array controller
    output logic arr_req,
    output ppp_arr_op_t arr_op,
    output logic [ADDR_W-1:0] arr_addr,
    output logic [15:0] arr_wdata,
    input wire logic arr_ack,
    input wire logic [15:0] arr_rdata
);
    // ************************************************************
    // Pin synchronisation
    // ************************************************************
    localparam int NPIN = 18;
    logic [NPIN-1:0] pins;
    logic [NPIN-1:0] s;
    logic [NPIN-1:0] sd;

    if (PAGE_WORDS != (1 << PAGE_IDX_W)) begin : g_chk_pg
        $error("ppp_top: PAGE_WORDS must match the word index width");
    end
    if (EE_PAGE_BYTES != (1 << EE_IDX_W)) begin : g_chk_ee
        $error("ppp_top: EE_PAGE_BYTES must match the EEPROM index width");
    end

    assign pins = {reset_pin_n, hv_level, strobe_clock_pin,
                   strobe_action_1, strobe_action_0,
                   byte_select_hi, byte_select_lo, page_latch_strobe,
                   wr_n, oe_n, data_in};

    // Every pin shares one latency, so data stay aligned with strobes.
    ppp_sync #(.W(NPIN)) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .pin(pins),
        .q(s),
        .q_d(sd)
    );

    logic rst_s;
    logic hv_s;
    logic [1:0] act_s;
    logic [1:0] bsel_s;
    logic pgl_s;
    logic oe_n_s;
    logic [7:0] data_s;
    logic xt_rise;
    logic pgl_rise;
    logic wr_fall;
    logic oe_fall;
    logic [3:0] pattern;

    assign rst_s = !s[17] && !s[16];
    assign hv_s = s[16];
    assign act_s = s[14:13];
    assign bsel_s = s[12:11];
    assign pgl_s = s[10];
    assign oe_n_s = s[8];
    assign data_s = s[7:0];
    assign xt_rise = s[15] && !sd[15];
    assign pgl_rise = s[10] && !sd[10];
    assign wr_fall = !s[9] && sd[9];
    assign oe_fall = !s[8] && sd[8];
    assign pattern = {pgl_s, act_s, bsel_s[0]};

    // ************************************************************
    // Programming mode entry
    // ************************************************************
    logic [2:0] tog_reg;
    logic fail_reg;
    logic [7:0] quiet_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tog_reg <= 3'h0;
            fail_reg <= 1'b0;
            quiet_reg <= 8'h00;
            prog_mode <= 1'b0;
        end else if (rst_s) begin
            prog_mode <= 1'b0;
            fail_reg <= 1'b0;
            quiet_reg <= 8'h00;
            if (xt_rise && tog_reg != ENTRY_TOGGLES) begin
                tog_reg <= tog_reg + 3'h1;
            end
        end else if (!hv_s) begin
            prog_mode <= 1'b0;
            tog_reg <= 3'h0;
        end else if (!prog_mode && !fail_reg) begin
            if (tog_reg != ENTRY_TOGGLES || pattern != 4'h0) begin
                fail_reg <= 1'b1;
            end else if (quiet_reg == 8'(ENTRY_QUIET_CYC - 1)) begin
                prog_mode <= 1'b1;
            end else begin
                quiet_reg <= quiet_reg + 8'h01;
            end
        end
    end

    // ************************************************************
    // Command, address and data loading
    // ************************************************************
    typedef enum {
        ST_IDLE, ST_ER_FLASH, ST_ER_EE, ST_ER_LOCK,
        ST_PG_RD, ST_PG_REQ, ST_PG_WAIT, ST_FETCH
    } ppp_state_t;
    ppp_state_t state_reg;
    logic busy;
    logic [7:0] cmd_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [7:0] dlo_reg;
    logic [7:0] dhi_reg;

    assign busy = (state_reg != ST_IDLE);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_reg <= CMD_NOP;
            addr_reg <= '0;
            dlo_reg <= 8'h00;
            dhi_reg <= 8'h00;
        end else if (prog_mode && xt_rise && !busy) begin
            unique case (act_s)
                ACT_ADDR: begin
                    if (bsel_s == BSEL_LO) begin
                        addr_reg[7:0] <= data_s;
                    end else if (bsel_s == BSEL_HI) begin
                        addr_reg[15:8] <= data_s;
                    end else if (bsel_s == BSEL_EXT) begin
                        addr_reg[23:16] <= data_s;
                    end
                end
                ACT_DATA: begin
                    if (bsel_s[0]) begin
                        dhi_reg <= data_s;
                    end else begin
                        dlo_reg <= data_s;
                    end
                end
                ACT_CMD: cmd_reg <= data_s;
                ACT_IDLE: begin
                end
            endcase
        end
    end

    // ************************************************************
    // Page buffer
    // ************************************************************
    logic is_flash_cmd;
    logic buf_we;
    logic [PAGE_IDX_W-1:0] buf_waddr;
    logic [15:0] buf_wdata;
    logic [PAGE_IDX_W-1:0] idx_reg;
    logic [15:0] buf_rdata;

    assign is_flash_cmd = (cmd_reg == CMD_WR_FLASH);
    assign buf_we = prog_mode && pgl_rise && !busy
                    && (is_flash_cmd || cmd_reg == CMD_WR_EE);
    assign buf_waddr = is_flash_cmd ? addr_reg[PAGE_IDX_W-1:0]
        : PAGE_IDX_W'(addr_reg[EE_IDX_W-1:0]);
    assign buf_wdata = {dhi_reg, dlo_reg};

    ppp_mem #(.W(16), .DEPTH(PAGE_WORDS), .AW(PAGE_IDX_W)) u_buf (
        .clk(clk),
        .arst_n(arst_n),
        .we(buf_we),
        .waddr(buf_waddr),
        .wdata(buf_wdata),
        .raddr(idx_reg),
        .rdata(buf_rdata)
    );

    // ************************************************************
    // Operation sequencer, fuses and locks
    // ************************************************************
    logic [7:0] fuse_lo_reg;
    logic [7:0] fuse_hi_reg;
    logic [7:0] fuse_ext_reg;
    logic [7:0] lock_reg;
    logic [15:0] rd_word_reg;
    logic pg_flash_reg;
    logic [PAGE_IDX_W-1:0] last_idx;
    logic [ADDR_W-1:0] pg_addr;

    assign last_idx = pg_flash_reg ? PAGE_IDX_W'(PAGE_WORDS - 1)
                                   : PAGE_IDX_W'(EE_PAGE_BYTES - 1);
    assign pg_addr = pg_flash_reg
        ? {addr_reg[ADDR_W-1:PAGE_IDX_W], idx_reg}
        : {addr_reg[ADDR_W-1:EE_IDX_W], idx_reg[EE_IDX_W-1:0]};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_IDLE;
            fuse_lo_reg <= FUSE_LO_RST;
            fuse_hi_reg <= FUSE_HI_RST;
            fuse_ext_reg <= FUSE_EXT_RST;
            lock_reg <= LOCK_RST;
            rd_word_reg <= 16'h0000;
            pg_flash_reg <= 1'b0;
            idx_reg <= '0;
            arr_req <= 1'b0;
            arr_op <= PPP_OP_NONE;
            arr_addr <= '0;
            arr_wdata <= 16'h0000;
        end else begin
            arr_req <= 1'b0;
            unique case (state_reg)
                ST_IDLE: begin
                    if (prog_mode && wr_fall) begin
                        if (cmd_reg == CMD_CHIP_ERASE) begin
                            arr_req <= 1'b1;
                            arr_op <= PPP_OP_ER_FLASH;
                            state_reg <= ST_ER_FLASH;
                        end else if ((is_flash_cmd || cmd_reg == CMD_WR_EE)
                                     && bsel_s == BSEL_LO) begin
                            pg_flash_reg <= is_flash_cmd;
                            idx_reg <= '0;
                            state_reg <= ST_PG_RD;
                        end else if (cmd_reg == CMD_WR_FUSE) begin
                            if (bsel_s == BSEL_LO) begin
                                fuse_lo_reg <= dlo_reg;
                            end else if (bsel_s == BSEL_HI) begin
                                fuse_hi_reg <= dlo_reg;
                            end else if (bsel_s == BSEL_EXT) begin
                                fuse_ext_reg <= dlo_reg;
                            end
                        end else if (cmd_reg == CMD_WR_LOCK) begin
                            // Lock bits only program; erase clears them.
                            lock_reg <= lock_reg & dlo_reg;
                        end
                    end else if (prog_mode && oe_fall
                                 && (cmd_reg == CMD_RD_FLASH
                                     || cmd_reg == CMD_RD_EE)) begin
                        arr_req <= 1'b1;
                        arr_op <= (cmd_reg == CMD_RD_FLASH)
                                  ? PPP_OP_RD_FLASH : PPP_OP_RD_EE;
                        arr_addr <= addr_reg;
                        state_reg <= ST_FETCH;
                    end
                end
                ST_ER_FLASH: begin
                    if (arr_ack) begin
                        if (!fuse_hi_reg[KEEP_EE_BIT]) begin
                            state_reg <= ST_ER_LOCK;
                        end else begin
                            arr_req <= 1'b1;
                            arr_op <= PPP_OP_ER_EE;
                            state_reg <= ST_ER_EE;
                        end
                    end
                end
                ST_ER_EE: begin
                    if (arr_ack) begin
                        state_reg <= ST_ER_LOCK;
                    end
                end
                ST_ER_LOCK: begin
                    lock_reg <= LOCK_RST;
                    state_reg <= ST_IDLE;
                end
                ST_PG_RD: state_reg <= ST_PG_REQ;
                ST_PG_REQ: begin
                    arr_req <= 1'b1;
                    arr_op <= pg_flash_reg ? PPP_OP_WR_FLASH
                                           : PPP_OP_WR_EE;
                    arr_addr <= pg_addr;
                    arr_wdata <= pg_flash_reg ? buf_rdata
                                 : {ERASED_BYTE, buf_rdata[7:0]};
                    state_reg <= ST_PG_WAIT;
                end
                ST_PG_WAIT: begin
                    if (arr_ack) begin
                        if (idx_reg == last_idx) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            idx_reg <= idx_reg + 1'b1;
                            state_reg <= ST_PG_RD;
                        end
                    end
                end
                ST_FETCH: begin
                    if (arr_ack) begin
                        rd_word_reg <= arr_rdata;
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Ready/busy and data bus
    // ************************************************************
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        unique case (cmd_reg)
            CMD_RD_SIG: begin
                if (bsel_s[0]) begin
                    rd_byte = CAL_BYTE;
                end else if (addr_reg[1:0] == 2'h0) begin
                    rd_byte = SIG_BYTE0;
                end else if (addr_reg[1:0] == 2'h1) begin
                    rd_byte = SIG_BYTE1;
                end else if (addr_reg[1:0] == SIG_LAST) begin
                    rd_byte = SIG_BYTE2;
                end
            end
            CMD_RD_FUSE: begin
                unique case (bsel_s)
                    BSEL_LO: rd_byte = fuse_lo_reg;
                    BSEL_HI: rd_byte = lock_reg;
                    BSEL_EXT: rd_byte = fuse_ext_reg;
                    BSEL_FHI: rd_byte = fuse_hi_reg;
                endcase
            end
            CMD_RD_FLASH: rd_byte = bsel_s[0] ? rd_word_reg[15:8]
                                              : rd_word_reg[7:0];
            CMD_RD_EE: rd_byte = rd_word_reg[7:0];
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ready_busy_n <= 1'b1;
            data_out <= 8'h00;
            data_oe <= 1'b0;
        end else begin
            // A fetch is not reported as busy; it ends in a few cycles.
            ready_busy_n <= !busy || state_reg == ST_FETCH;
            data_out <= rd_byte;
            data_oe <= prog_mode && !oe_n_s;
        end
    end
endmodule // ppp_top

//--- test/ppp_checker.sv
/* Assertions on the programming port outputs.
   Bound to ppp_top below; sees only its ports. */
`timescale 1ns/10ps
module ppp_checker
    import ppp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Pins
    input wire logic hv_level,
    input wire logic strobe_action_0,
    input wire logic strobe_action_1,
    input wire logic byte_select_lo,
    input wire logic page_latch_strobe,
    input wire logic oe_n,
    // Outputs
    input wire logic data_oe,
    input wire logic ready_busy_n,
    input wire logic prog_mode,
    input wire logic arr_req,
    input wire ppp_arr_op_t arr_op
);
    // ****
    // Properties
    // ****
    logic [3:0] pat;
    assign pat = {page_latch_strobe, strobe_action_1, strobe_action_0,
        byte_select_lo};
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    oe_off_a: assert property (oe_n [*4] |-> !data_oe)
        else $error("bus driven while disabled");
    oe_on_a: assert property ((!oe_n && prog_mode) [*4] |-> data_oe)
        else $error("bus not driven");
    erase_busy_a: assert property (arr_req && arr_op == PPP_OP_ER_FLASH
        |=> !ready_busy_n) else $error("ready during erase");
    ee_erase_a: assert property (arr_req && arr_op == PPP_OP_ER_EE
        |-> !ready_busy_n) else $error("ready during erase");
    page_busy_a: assert property (arr_req && arr_op inside
        {PPP_OP_WR_FLASH, PPP_OP_WR_EE} |-> !ready_busy_n)
        else $error("ready during page write");
    idle_req_a: assert property (!prog_mode |-> !arr_req)
        else $error("request outside mode");
    op_known_a: assert property (arr_req |-> arr_op != PPP_OP_NONE)
        else $error("request without operation");
    hv_drop_a: assert property (!hv_level [*4] |-> !prog_mode)
        else $error("mode without high voltage");
    entry_pat_a: assert property ($past(pat, 3) != 4'h0
        |-> !$rose(prog_mode)) else $error("entry with pattern set");
endmodule // ppp_checker

bind ppp_top ppp_checker u_chk (.clk(clk), .arst_n(arst_n),
    .hv_level(hv_level), .strobe_action_0(strobe_action_0),
    .strobe_action_1(strobe_action_1), .byte_select_lo(byte_select_lo),
    .page_latch_strobe(page_latch_strobe), .oe_n(oe_n), .data_oe(data_oe),
    .ready_busy_n(ready_busy_n), .prog_mode(prog_mode), .arr_req(arr_req),
    .arr_op(arr_op));

//--- test/ppp_arr_model.sv
/* Behavioural array controller with Flash and EEPROM cells.
   Assumes one request at a time; lat adds wait cycles per answer. */
`timescale 1ns/10ps
module ppp_arr_model
    import ppp_pkg::*;
(
    // Clock
    input wire logic clk,
    // Requests
    input wire logic arr_req,
    input wire ppp_arr_op_t arr_op,
    input wire logic [ADDR_W-1:0] arr_addr,
    input wire logic [15:0] arr_wdata,
    output logic arr_ack,
    output logic [15:0] arr_rdata,
    input wire logic [3:0] lat
);
    // ****
    // Cells
    // ****
    logic [15:0] flash [256];
    logic [7:0] ee [256];
    logic [7:0] a;
    logic [15:0] d;
    ppp_arr_op_t o;
    initial arr_ack = 1'b0;
    initial arr_rdata = 16'h0000;
    // Read data churns outside the answer so early sampling is caught.
    always @(posedge clk) begin
        arr_ack <= 1'b0;
        arr_rdata <= ~arr_rdata;
        if (arr_req) begin
            a = arr_addr[7:0];
            d = arr_wdata;
            o = arr_op;
            repeat (lat) @(posedge clk);
            case (o)
                PPP_OP_WR_FLASH: flash[a] = d;
                PPP_OP_WR_EE: ee[a] = d[7:0];
                PPP_OP_ER_FLASH: foreach (flash[i]) flash[i] = 16'hFFFF;
                PPP_OP_ER_EE: foreach (ee[i]) ee[i] = 8'hFF;
                PPP_OP_RD_FLASH: arr_rdata <= flash[a];
                PPP_OP_RD_EE: arr_rdata <= {8'hFF, ee[a]};
                default: ;
            endcase
            arr_ack <= 1'b1;
        end
    end
endmodule // ppp_arr_model

//--- test/ppp_top_tb.sv
/* Self-checking bench: plays the programmer on the pins.
   Assumes ppp_arr_model answers the array requests. */
`timescale 1ns/10ps
module ppp_top_tb import ppp_pkg::*;;
    // ****
    // Bench
    // ****
    localparam logic [7:0] SIG1 = 8'h6B;  // Arbitrary value.
    logic clk = 1'b0;
    logic arst_n, rp_n, hv, sclk, pl, wr_n, oe_n, oe, rb, pm, req, ack;
    logic [1:0] act, bs;
    logic [3:0] lat;
    logic [7:0] din, dout, lk, fz [3];
    logic [15:0] rdat, wd, w [64];
    logic [ADDR_W-1:0] addr;
    ppp_arr_op_t op;
    int failures = 0, n_tests = 0, k;
    always #2 clk = ~clk;
    ppp_top #(.SIG_BYTE1(SIG1)) DUT (.clk(clk), .arst_n(arst_n),
        .reset_pin_n(rp_n), .hv_level(hv), .strobe_clock_pin(sclk),
        .strobe_action_0(act[0]), .strobe_action_1(act[1]),
        .byte_select_lo(bs[0]), .byte_select_hi(bs[1]),
        .page_latch_strobe(pl), .wr_n(wr_n), .oe_n(oe_n), .data_in(din),
        .data_out(dout), .data_oe(oe), .ready_busy_n(rb), .prog_mode(pm),
        .arr_req(req), .arr_op(op), .arr_addr(addr), .arr_wdata(wd),
        .arr_ack(ack), .arr_rdata(rdat));
    ppp_arr_model M (.clk(clk), .arr_req(req), .arr_op(op),
        .arr_addr(addr), .arr_wdata(wd), .arr_ack(ack), .arr_rdata(rdat),
        .lat(lat));
    task automatic stop_test();
        if (failures == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    function automatic logic [7:0] pick(logic [15:0] v, logic hi);
        return hi ? v[15:8] : v[7:0];
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One strobe period of 48 ns, rising in its middle.
    task automatic load(input logic [1:0] a, b, input logic [7:0] d);
        act <= a;
        bs <= b;
        din <= d;
        tick(6);
        sclk <= 1'b1;
        tick(6);
        sclk <= 1'b0;
    endtask
    task automatic latch();
        pl <= 1'b1;
        tick(6);
        pl <= 1'b0;
        tick(6);
    endtask
    task automatic wr(input logic [1:0] b);
        int i;
        bs <= b;
        wr_n <= 1'b0;
        tick(6);
        wr_n <= 1'b1;
        tick(4);
        for (i = 0; i < 20000 && rb !== 1'b1; i++) tick(1);
        if (i == 20000) begin
            failures++;
            stop_test();
        end
    endtask
    task automatic rd(input logic [1:0] b, input logic [7:0] e);
        bs <= b;
        oe_n <= 1'b0;
        tick(20);
        chk(oe, 1'b1);
        chk(dout, e);
        oe_n <= 1'b1;
        tick(6);
        chk(oe, 1'b0);
    endtask
    task automatic rd_fuses(input logic [7:0] le);
        load(ACT_CMD, BSEL_LO, CMD_RD_FUSE);
        rd(BSEL_LO, fz[0]);
        rd(BSEL_FHI, fz[1]);
        rd(BSEL_EXT, fz[2]);
        rd(BSEL_HI, le);
    endtask
    initial begin
        {arst_n, rp_n, hv, sclk, pl, act, bs, din, lat} = '0;
        wr_n = 1'b1;
        oe_n = 1'b1;
        void'($urandom(32'hEC849EE4));
        tick(6);
        arst_n <= 1'b1;
        tick(4);
        repeat (6) load(ACT_ADDR, BSEL_LO, 8'h00);
        act <= ACT_DATA;
        hv <= 1'b1;
        tick(40);
        chk(pm, 1'b0);
        {act, hv} <= '0;
        tick(30);
        hv <= 1'b1;
        tick(40);
        chk(pm, 1'b1);
        tick(12500);
        // Keep-EEPROM fuse stays unprogrammed so the erase reaches EEPROM.
        load(ACT_CMD, BSEL_LO, CMD_WR_FUSE);
        for (k = 0; k < 3; k++) begin
            fz[k] = 8'($urandom) | 8'h08;
            load(ACT_DATA, BSEL_LO, fz[k]);
            wr(k[1:0]);
        end
        lk = 8'($urandom);
        load(ACT_CMD, BSEL_LO, CMD_WR_LOCK);
        load(ACT_DATA, BSEL_LO, lk);
        wr(BSEL_LO);
        rd_fuses(lk);
        load(ACT_CMD, BSEL_LO, CMD_CHIP_ERASE);
        wr(BSEL_LO);
        rd_fuses(8'hFF);
        chk(M.ee[7], 8'hFF);
        lat <= 4'($urandom_range(7));
        load(ACT_CMD, BSEL_LO, CMD_WR_FLASH);
        load(ACT_ADDR, BSEL_HI, 8'h00);
        for (k = 0; k < 64; k++) begin
            w[k] = 16'($urandom);
            load(ACT_ADDR, BSEL_LO, 8'(k));
            load(ACT_DATA, BSEL_LO, w[k][7:0]);
            load(ACT_DATA, BSEL_HI, w[k][15:8]);
            latch();
        end
        wr(BSEL_LO);
        for (k = 0; k < 64; k++) chk(M.flash[k], w[k]);
        load(ACT_CMD, BSEL_LO, CMD_RD_FLASH);
        repeat (4) begin
            k = $urandom_range(63);
            load(ACT_ADDR, BSEL_LO, 8'(k));
            load(ACT_IDLE, BSEL_LO, 8'h00);
            rd(BSEL_LO, pick(w[k], 1'b0));
            rd(BSEL_HI, pick(w[k], 1'b1));
        end
        load(ACT_CMD, BSEL_LO, CMD_WR_EE);
        for (k = 0; k < 4; k++) begin
            load(ACT_ADDR, BSEL_LO, 8'(k + 4));
            load(ACT_DATA, BSEL_LO, w[k][7:0]);
            latch();
        end
        wr(BSEL_LO);
        load(ACT_CMD, BSEL_LO, CMD_RD_EE);
        for (k = 0; k < 4; k++) begin
            chk(M.ee[k + 4], w[k][7:0]);
            load(ACT_ADDR, BSEL_LO, 8'(k + 4));
            rd(BSEL_LO, w[k][7:0]);
        end
        load(ACT_CMD, BSEL_LO, CMD_RD_SIG);
        load(ACT_ADDR, BSEL_LO, 8'h01);
        rd(BSEL_LO, SIG1);
        hv <= 1'b0;
        tick(8);
        chk(pm, 1'b0);
        stop_test();
    end
endmodule // ppp_top_tb
